//--- mld_pkg.sv
/*
  constants, field layouts and types shared by the multiplexed led display controller.
  assumes a 100 mhz aclk and an axi4-lite register master with 32-bit data.
*/
package mld_pkg;
  // clock and refresh timing
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 86800;
  localparam int TICK_CYC_DEF = TICK_NS / CLK_NS;
  localparam logic [7:0] PRELOAD_RST = 8'hE3;
  localparam logic [7:0] TIMER_LAST = 8'hFF;
  localparam int DIGITS = 8;
  localparam logic [2:0] DIGIT_LAST = 3'h7;

  // register byte addresses
  localparam int AW = 8;
  localparam logic [AW-1:0] ADDR_DATA = 8'h00;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h04;
  localparam logic [AW-1:0] ADDR_PRELOAD = 8'h08;
  localparam logic [AW-1:0] ADDR_MAP = 8'h20;
  localparam logic [AW-1:0] MAP_MASK = 8'hE3;

  // status fields
  localparam int ST_IBF_BIT = 0;
  localparam int ST_PEND_BIT = 1;
  localparam int ST_CUR_LSB = 4;

  // display data word layout
  localparam int DIG_LSB = 0;
  localparam int DIG_W = 3;
  localparam int CHR_LSB = 3;
  localparam int CHR_W = 5;
  localparam logic [4:0] CHR_DP = 5'h1F;
  localparam logic [7:0] SEG_DP = 8'h80;
  localparam logic [7:0] SEG_BLANK = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_BLANK, ST_SEG, ST_SEL, ST_EN} mld_step_t;
endpackage : mld_pkg

//--- mld_char_rom.sv
/*
  character code to segment pattern lookup (bit0 = a ... bit6 = g, bit7 = dp).
  assumes a 5-bit code; unlisted codes show blank.
*/
`timescale 1ns/1ns
module mld_char_rom
  import mld_pkg::*;
(
  input wire logic [4:0] code,
  output logic [7:0] seg
);
  always_comb begin
    unique case (code)
      5'h00: seg = 8'h3F;
      5'h01: seg = 8'h06;
      5'h02: seg = 8'h5B;
      5'h03: seg = 8'h4F;
      5'h04: seg = 8'h66;
      5'h05: seg = 8'h6D;
      5'h06: seg = 8'h7D;
      5'h07: seg = 8'h07;
      5'h08: seg = 8'h7F;
      5'h09: seg = 8'h6F;
      5'h0A: seg = 8'h77;
      5'h0B: seg = 8'h7C;
      5'h0C: seg = 8'h39;
      5'h0D: seg = 8'h5E;
      5'h0E: seg = 8'h79;
      5'h0F: seg = 8'h71;
      5'h10: seg = 8'h76;
      5'h11: seg = 8'h38;
      5'h12: seg = 8'h73;
      5'h13: seg = 8'h3E;
      5'h14: seg = 8'h40;
      5'h15: seg = 8'h50;
      5'h16: seg = 8'h5C;
      default: seg = SEG_BLANK;
    endcase
  end
endmodule : mld_char_rom

//--- mld_ctrl.sv
/*
  eight-digit multiplexed led display controller with an axi4-lite register slave.
  assumes one 100 mhz clock, a synchronous active-low reset and external
  segment drivers plus a 3-to-8 digit decoder with an active-high enable.
*/
`timescale 1ns/1ns
// Notes on behaviour
// R1: host write fills buffer, flag taken
// R2: word splits into digit and character
// R3: character looked up, stored in map
// R4: decimal point merges into existing pattern
// R5: each timer expiry runs one step
// R6: decoder disabled before segments change
// R7: map entry of digit drives segments
// R8: digit number out, then decoder enabled
// R9: digit counter advances, wraps after eight
// R10: timer reloaded at end of step
// R11: lit digit held until next step
// R12: host checks flag clear before writing
// R13: whole display refreshed at about 49.7 hz
// R14: 8-bit up timer, preload 227, settable
// R15: three digit lines plus enable line
// R16: display map holds eight patterns
// R17: reset blanks outputs, map, starts timer
// R18: three digit bits, five character bits
// R19: write and expiry together both served
module mld_ctrl
  import mld_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] seg_out,
  output logic [2:0] digit_sel,
  output logic digit_dec_en
);
  localparam logic [13:0] TICK_LAST = 14'(TICK_CYC - 1);

  typedef struct packed {
    logic [DIGITS-1:0][7:0] map;
    logic [7:0] host_input_buffer;
    logic input_buffer_full_flag;
    logic pend;
    logic [7:0] timer;
    logic [13:0] pre;
    logic [7:0] preload;
    logic [2:0] cur;
    mld_step_t step;
    logic [7:0] seg;
    logic [2:0] sel;
    logic en;
    logic aw_have;
    logic [AW-1:0] awaddr;
    logic w_have;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
  } mld_state_t;

  mld_state_t q;
  mld_state_t d;
  logic [7:0] rom_seg;
  logic tick;
  logic expire;
  logic [2:0] wr_dig;
  logic [4:0] wr_chr;

  // R2: field split of the held word
  // R18: digit in low bits, character above
  assign wr_dig = q.host_input_buffer[DIG_LSB +: DIG_W];
  assign wr_chr = q.host_input_buffer[CHR_LSB +: CHR_W];

  mld_char_rom u_rom (
    .code(wr_chr),
    .seg(rom_seg)
  );

  // R14: timer runs only while no step is owed
  assign tick = (q.pre == TICK_LAST);
  assign expire = tick && !q.pend && (q.timer == TIMER_LAST);

  always_comb begin
    d = q;
    d.pre = tick ? 14'h0000 : q.pre + 14'h0001;

    // R14: up-count from preload to overflow
    // R13: default preload gives about 397 steps per second
    if (tick && !q.pend) begin
      d.timer = q.timer + 8'h01;
    end
    // R5: overflow marks one step owed
    if (expire) begin
      d.pend = 1'b1;
    end

    // R1: buffered word consumed in one cycle
    if (q.input_buffer_full_flag) begin
      d.input_buffer_full_flag = 1'b0;
      // R4: decimal point or-ed into pattern
      if (wr_chr == CHR_DP) begin
        d.map[wr_dig] = q.map[wr_dig] | SEG_DP;
      end else begin
        // R3: lookup result replaces pattern
        d.map[wr_dig] = rom_seg;
      end
    end

    unique case (q.step)
      ST_IDLE: begin
        // R19: owed step starts even during a write
        if (q.pend) begin
          d.step = ST_BLANK;
        end
      end
      ST_BLANK: begin
        // R6: digit drivers off first
        d.en = 1'b0;
        d.pend = 1'b0;
        d.step = ST_SEG;
      end
      ST_SEG: begin
        // R7: current digit's pattern to segments
        d.seg = q.map[q.cur];
        d.step = ST_SEL;
      end
      ST_SEL: begin
        // R15: digit number to decoder lines
        d.sel = q.cur;
        d.step = ST_EN;
      end
      ST_EN: begin
        // R8: enable lights the selected digit
        d.en = 1'b1;
        // R9: wrap after the eighth digit
        d.cur = (q.cur == DIGIT_LAST) ? 3'h0 : q.cur + 3'h1;
        // R10: reload and restart the interval
        d.timer = q.preload;
        d.pre = 14'h0000;
        d.step = ST_IDLE;
      end
      // three codes unused: fall back to idle
      default: begin
        d.step = ST_IDLE;
      end
    endcase

    // write channel: address and data taken in either order
    if (s_axi_awvalid && !q.aw_have && !q.bvalid) begin
      d.aw_have = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_have && !q.bvalid) begin
      d.w_have = 1'b1;
      d.wdata = s_axi_wdata[7:0];
      d.wstrb0 = s_axi_wstrb[0];
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (q.awaddr == ADDR_DATA) begin
        // R12: a write into a full buffer is refused, not merged
        if (q.input_buffer_full_flag) begin
          d.bresp = RESP_SLVERR;
        end else if (q.wstrb0) begin
          // R1: word latched and flag raised
          d.host_input_buffer = q.wdata;
          d.input_buffer_full_flag = 1'b1;
        end
      end else if (q.awaddr == ADDR_PRELOAD) begin
        // R14: preload is software settable
        if (q.wstrb0) begin
          d.preload = q.wdata;
        end
      end else if (q.awaddr == ADDR_STATUS || (q.awaddr & MAP_MASK) == ADDR_MAP) begin
        d.bresp = RESP_OKAY;
      end else begin
        d.bresp = RESP_SLVERR;
      end
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // read channel: one read in flight, answered the next cycle
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = 32'h0000_0000;
      if (s_axi_araddr == ADDR_DATA) begin
        d.rdata[7:0] = q.host_input_buffer;
      end else if (s_axi_araddr == ADDR_STATUS) begin
        d.rdata[ST_IBF_BIT] = q.input_buffer_full_flag;
        d.rdata[ST_PEND_BIT] = q.pend;
        d.rdata[ST_CUR_LSB +: 3] = q.cur;
      end else if (s_axi_araddr == ADDR_PRELOAD) begin
        d.rdata[7:0] = q.preload;
      end else if ((s_axi_araddr & MAP_MASK) == ADDR_MAP) begin
        // R16: each map entry readable
        d.rdata[7:0] = q.map[s_axi_araddr[4:2]];
      end else begin
        d.rresp = RESP_SLVERR;
      end
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // readies registered so every port leaves a flip-flop
    d.aw_rdy = !d.aw_have && !d.bvalid;
    d.w_rdy = !d.w_have && !d.bvalid;
    d.ar_rdy = !d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // R17: all drivers off, map blank, timer loaded
      q <= '0;
      q.preload <= PRELOAD_RST;
      q.timer <= PRELOAD_RST;
      q.step <= ST_IDLE;
      q.aw_rdy <= 1'b1;
      q.w_rdy <= 1'b1;
      q.ar_rdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.aw_rdy;
  assign s_axi_wready = q.w_rdy;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.ar_rdy;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign seg_out = q.seg;
  assign digit_sel = q.sel;
  assign digit_dec_en = q.en;

  // checks
  a_ibf_taken: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    q.input_buffer_full_flag |=> !q.input_buffer_full_flag) else $error("buffered word not consumed");
  a_char_stored: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    q.input_buffer_full_flag && wr_chr != CHR_DP |=> q.map[$past(wr_dig)] == $past(rom_seg))
    else $error("lookup pattern not stored");
  a_dp_merge: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    q.input_buffer_full_flag && wr_chr == CHR_DP |=> q.map[$past(wr_dig)] == ($past(q.map[wr_dig]) | SEG_DP))
    else $error("decimal point not merged");
  a_expiry_step: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    expire && q.step == ST_IDLE |=> ##1 q.step == ST_BLANK ##4 $rose(digit_dec_en))
    else $error("expiry did not run a step");
  a_blank_first: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    $changed(seg_out) |-> !digit_dec_en && $past(!digit_dec_en)) else $error("segments changed while lit");
  a_seg_from_map: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    q.step == ST_SEL |-> seg_out == $past(q.map[q.cur])) else $error("segments not from map");
  a_sel_then_en: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    $rose(digit_dec_en) |-> $stable(digit_sel) && digit_sel == $past(q.cur, 2)) else $error("enable before digit select");
  a_digit_wrap: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    q.step == ST_EN |=> q.cur == ($past(q.cur) == DIGIT_LAST ? 3'h0 : $past(q.cur) + 3'h1)) else $error("digit counter wrong");
  a_timer_reload: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    q.step == ST_EN |=> q.timer == $past(q.preload) && q.pre == 14'h0000) else $error("timer not reloaded");
  a_lit_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    q.step == ST_IDLE && !q.pend |=> $stable(seg_out) && $stable(digit_sel) && $stable(digit_dec_en))
    else $error("display changed between steps");
  a_reset_blank: assert property (@(posedge aclk) // R17
    $past(!aresetn) |-> seg_out == SEG_BLANK && !digit_dec_en && q.timer == PRELOAD_RST) else $error("reset not blank");
  a_coincide: assert property (@(posedge aclk) disable iff (!aresetn) // R19
    expire && q.input_buffer_full_flag |=> q.pend && !q.input_buffer_full_flag) else $error("coincident event lost");

  c_wrap: cover property (@(posedge aclk) disable iff (!aresetn) q.step == ST_EN && q.cur == DIGIT_LAST);
  c_dp: cover property (@(posedge aclk) disable iff (!aresetn) q.input_buffer_full_flag && wr_chr == CHR_DP);
  c_both: cover property (@(posedge aclk) disable iff (!aresetn) expire && q.input_buffer_full_flag);
endmodule : mld_ctrl

//--- mld_led_panel.sv
/* led panel model: latches the pattern each digit shows when lit.
   assumes active-high segments and an active-high decoder enable. */
`timescale 1ns/1ns
module mld_led_panel (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] seg_out,
  input wire logic [2:0] digit_sel,
  input wire logic digit_dec_en,
  output logic [7:0] lit [8],
  output int steps,
  output int gap,
  output int bad
);
  logic en_q;
  logic [7:0] seg_q;
  logic [2:0] dig_q;
  int cyc;
  always @(posedge aclk) begin
    en_q <= digit_dec_en;
    seg_q <= seg_out;
    dig_q <= digit_sel;
    cyc <= cyc + 1;
    if (!aresetn) begin
      steps <= 0;
      bad <= 0;
      cyc <= 0;
    end else begin
      if (en_q && digit_dec_en && (seg_q != seg_out || dig_q != digit_sel)) bad <= bad + 1;
      if (digit_dec_en && !en_q) begin
        if (digit_sel != 3'(steps) || dig_q != digit_sel || seg_q != seg_out) bad <= bad + 1;
        lit[digit_sel] <= seg_out;
        steps <= steps + 1;
        gap <= cyc;
        cyc <= 0;
      end
    end
  end
endmodule : mld_led_panel

//--- test_multiplexed_led_display_ctrl.sv
/* self-checking bench: axi4-lite host tasks, a reference map model,
   and the led panel model watching the display outputs. */
`timescale 1ns/1ns
module test_multiplexed_led_display_ctrl;
  import mld_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, den;
  logic [AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] seg;
  logic [7:0] lit [8];
  logic [2:0] dsel;
  int steps, gap, bad, err_count, total_checks, seed, n0;
  int mdl [8];
  mld_ctrl #(.TICK_CYC(4)) mld_ctrl_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .seg_out(seg), .digit_sel(dsel), .digit_dec_en(den));
  mld_led_panel mld_led_panel_i (.aclk(aclk), .aresetn(aresetn), .seg_out(seg), .digit_sel(dsel),
    .digit_dec_en(den), .lit(lit), .steps(steps), .gap(gap), .bad(bad));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  function automatic logic [7:0] rom(input int c);
    logic [7:0] t [23] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D, 8'h07, 8'h7F, 8'h6F, 8'h77,
      8'h7C, 8'h39, 8'h5E, 8'h79, 8'h71, 8'h76, 8'h38, 8'h73, 8'h3E, 8'h40, 8'h50, 8'h5C};
    return (c < 23) ? t[c] : SEG_BLANK;
  endfunction : rom
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      err_count++;
      $display("FAIL %0t wait ran out", $time);
      stop_test();
    end
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
    tmo(n, 200);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rv = rdata;
    resp = rresp;
    rready <= 1'b0;
    tmo(n, 200);
  endtask : rd
  task automatic put(input int d, input int c);
    int n;
    for (n = 0; n < 50; n++) begin
      rd(ADDR_STATUS);
      if (rv[ST_IBF_BIT] === 1'b0) break;
    end
    tmo(n, 50);
    wr(ADDR_DATA, 32'((c << 3) | d), 4'h1);
    chk(resp, RESP_OKAY);
    mdl[d] = (c == int'(CHR_DP)) ? (mdl[d] | int'(SEG_DP)) : int'(rom(c));
  endtask : put
  task automatic cmp_map;
    for (int i = 0; i < DIGITS; i++) begin
      rd(ADDR_MAP + 8'(4 * i));
      chk(rv, 32'(mdl[i]));
    end
  endtask : cmp_map
  initial begin
    seed = 32'h52C2CCBE;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    err_count = 0;
    total_checks = 0;
    foreach (mdl[i]) mdl[i] = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    chk({seg, dsel, den}, 32'h0);
    rd(ADDR_PRELOAD);
    chk(rv, 32'(PRELOAD_RST));
    cmp_map();
    wr(ADDR_PRELOAD, 32'hFC, 4'h1);
    rd(ADDR_PRELOAD);
    chk(rv, 32'hFC);
    rd(8'h10);
    chk(resp, RESP_SLVERR);
    chk(rv, 32'h0);
    wr(8'h14, 32'h1, 4'h1);
    chk(resp, RESP_SLVERR);
    // every code once, random digits, refresh running alongside
    for (int c = 0; c < 32; c++) put($random(seed) & 7, c);
    put(3, 5);
    put(3, 31);
    put(6, 31);
    put(6, 2);
    wr(ADDR_DATA, 32'h0B, 4'h0);
    chk(resp, RESP_OKAY);
    rd(ADDR_DATA);
    chk(rv, 32'((2 << 3) | 6));
    wr(ADDR_MAP + 8'h04, 32'hFF, 4'h1);
    chk(resp, RESP_OKAY);
    cmp_map();
    n0 = steps;
    for (int n = 0; n < 5000; n++) begin
      @(posedge aclk);
      if (steps >= n0 + 17 || n == 4999) begin
        tmo(n + 1, 5000);
        break;
      end
    end
    for (int i = 0; i < DIGITS; i++) chk(lit[i], 32'(mdl[i]));
    chk(bad, 0);
    chk(32'(gap >= 16 && gap <= 26), 32'h1);
    // second reset mid-run: map must come back blank
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (mdl[i]) mdl[i] = 0;
    @(posedge aclk);
    chk({seg, dsel, den}, 32'h0);
    rd(ADDR_PRELOAD);
    chk(rv, 32'(PRELOAD_RST));
    cmp_map();
    stop_test();
  end
endmodule : test_multiplexed_led_display_ctrl
